// file: scan_capture_regs.svh
// constants of the scan target capture block: geometry, widths, timing
`ifndef SCAN_CAPTURE_REGS_SVH
`define SCAN_CAPTURE_REGS_SVH

`define V_W 9
`define H_W 9
`define V_LAST 9'h1ff
`define H_LAST 9'h1ff
`define SCAN_COUNT 512
`define FRAME_STEPS 19'h4_0000
`define STEP_W 19
`define RAW_W 10
`define RAW_AW 12
`define CNT_W 10
`define PROC_AW 10
`define WORD_W 16
`define CACHE_AW 6
`define PIX_DIV 4
`define DIV_W 8
`define CLK_PERIOD_NS 100
`define GRAT_TIME_NS 50000
`define GRAT_CYC (`GRAT_TIME_NS / `CLK_PERIOD_NS)
`define DUTY_WIN_NS 10000000
`define DUTY_WIN_CYC (`DUTY_WIN_NS / `CLK_PERIOD_NS)
`define DUTY_MAX_PCT 50

`endif

// file: scan_capture_pkg.sv
// types shared by the scan target capture block
package scan_capture_pkg;
  typedef enum logic [2:0] {RD_DUMP, RD_VERT, RD_COUNT, RD_PTR, RD_PROC} rd_mode_t;
  typedef struct packed {
    rd_mode_t mode;
    logic [11:0] addr;
  } rd_cmd_t;
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } rd_ans_t;
  typedef enum {ST_IDLE, ST_CAPTURE, ST_FLUSH} cap_state_t;
endpackage

// file: scan_target_data_capture.sv
// scan target data capture: read pacing, edge capture, cache, raw/processed memory
`timescale 1ns/1ns
`include "scan_capture_regs.svh"

module scan_target_data_capture #(
  parameter int PIX_DIV = `PIX_DIV,
  parameter int CACHE_AW = `CACHE_AW,
  parameter int DUTY_WIN = `DUTY_WIN_CYC,
  parameter int DUTY_MAX_PCT = `DUTY_MAX_PCT
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // reading side
  input wire logic VIDEO_IN,
  input wire logic TV_MODE,
  input wire logic TV_XGATE_IN,
  input wire logic TV_YGATE_IN,
  output logic READ_STEP,
  output logic X_RAMP_SYNC,
  output logic Y_RAMP_SYNC,
  // writing side
  input wire logic SWEEP_GATE,
  input wire logic WRITE_BEAM_ON,
  output logic GRAT_SELECT,
  output logic INTENSITY_LIMIT,
  // digitize control
  input wire logic DIG_START,
  output logic DIG_BUSY,
  output logic DIG_DONE,
  output logic CACHE_OVERFLOW,
  // memory access
  input wire logic RD_REQ,
  input wire scan_capture_pkg::rd_cmd_t RD_CMD,
  input wire logic PROC_WE,
  input wire logic [`PROC_AW-1:0] PROC_ADDR,
  input wire logic [`WORD_W-1:0] PROC_WDATA,
  output scan_capture_pkg::rd_ans_t RD_ANS
);
  import scan_capture_pkg::*;

  localparam int CDEPTH = 2 ** CACHE_AW;
  localparam int RAW_DEPTH = 2 ** `RAW_AW;
  localparam logic [31:0] DUTY_LIM = 32'(longint'(DUTY_WIN) * DUTY_MAX_PCT / 100);

  ////////////////////////////////////////////////////////////////////////////
  // read pacing and beam position

  logic [`DIV_W-1:0] div_ff;
  logic [`V_W-1:0] v_ff;
  logic [`H_W-1:0] h_ff;
  logic step, scan_end, frame_end;
  logic tvx_d_ff, tvy_d_ff;

  assign step = (div_ff == `DIV_W'(PIX_DIV - 1));
  assign scan_end = step && (v_ff == `V_LAST);
  assign frame_end = scan_end && (h_ff == `H_LAST);

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      div_ff <= '0;
      READ_STEP <= 1'b0;
    end else begin
      div_ff <= step ? '0 : div_ff + 1'b1;
      READ_STEP <= step;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      v_ff <= '0;
      h_ff <= '0;
    end else if (step) begin
      v_ff <= v_ff + 1'b1;
      if (v_ff == `V_LAST)
        h_ff <= h_ff + 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      tvx_d_ff <= 1'b0;
      tvy_d_ff <= 1'b0;
      X_RAMP_SYNC <= 1'b0;
      Y_RAMP_SYNC <= 1'b0;
    end else begin
      tvx_d_ff <= TV_XGATE_IN;
      tvy_d_ff <= TV_YGATE_IN;
      X_RAMP_SYNC <= TV_MODE ? (TV_XGATE_IN && !tvx_d_ff) : frame_end;
      Y_RAMP_SYNC <= TV_MODE ? (TV_YGATE_IN && !tvy_d_ff) : scan_end;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // digitize sequence

  cap_state_t state_ff;
  logic [`STEP_W-1:0] steps_left_ff;
  logic [`H_W-1:0] start_h_ff;
  logic capturing, finish, cache_empty, accept;

  // a refused start (busy or tv mode) must leave every pointer alone
  assign accept = DIG_START && (state_ff == ST_IDLE) && !TV_MODE;
  assign capturing = (state_ff == ST_CAPTURE);
  assign finish = capturing && step && (steps_left_ff == `STEP_W'(1));

  // one full frame from the current position
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state_ff <= ST_IDLE;
      steps_left_ff <= '0;
      start_h_ff <= '0;
      DIG_BUSY <= 1'b0;
      DIG_DONE <= 1'b0;
    end else begin
      DIG_DONE <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          // capture only starts in digital mode
          if (accept) begin
            state_ff <= ST_CAPTURE;
            steps_left_ff <= `FRAME_STEPS;
            start_h_ff <= h_ff;
            DIG_BUSY <= 1'b1;
          end
        end
        ST_CAPTURE: begin
          if (step)
            steps_left_ff <= steps_left_ff - 1'b1;
          if (finish)
            state_ff <= ST_FLUSH;
        end
        ST_FLUSH: begin
          if (cache_empty) begin
            state_ff <= ST_IDLE;
            DIG_BUSY <= 1'b0;
            DIG_DONE <= 1'b1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge detection and cache

  logic vid_ff;
  logic push, pop, cache_full;
  logic [`RAW_W-1:0] cache_mem [CDEPTH];
  logic [CACHE_AW:0] cwr_ff, crd_ff;
  logic [`RAW_AW:0] pushed_ff, drained_ff, wrap_base_ff;
  logic [`CNT_W-1:0] scan_cnt_ff, cnt_now;

  assign cache_empty = (cwr_ff == crd_ff);
  assign cache_full = (cwr_ff[CACHE_AW] != crd_ff[CACHE_AW]) &&
                      (cwr_ff[CACHE_AW-1:0] == crd_ff[CACHE_AW-1:0]);
  // every video transition during capture is a point while cache and raw memory have room
  assign push = capturing && step && (VIDEO_IN != vid_ff) && !cache_full &&
                (pushed_ff != (`RAW_AW+1)'(RAW_DEPTH));
  assign pop = !cache_empty;
  assign cnt_now = scan_cnt_ff + `CNT_W'(push);

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN)
      vid_ff <= 1'b0;
    else if (step)
      vid_ff <= VIDEO_IN;
  end

  // points parked in fast cache; word keeps edge polarity
  always_ff @(posedge CLOCK) begin
    if (push)
      cache_mem[cwr_ff[CACHE_AW-1:0]] <= {VIDEO_IN, v_ff};
  end

  // overflow loses points; depth must cover the busiest scan
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      cwr_ff <= '0;
      crd_ff <= '0;
      CACHE_OVERFLOW <= 1'b0;
    end else begin
      if (push)
        cwr_ff <= cwr_ff + 1'b1;
      if (pop)
        crd_ff <= crd_ff + 1'b1;
      if (accept)
        CACHE_OVERFLOW <= 1'b0;
      else if (capturing && step && (VIDEO_IN != vid_ff) && cache_full)
        CACHE_OVERFLOW <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN)
      scan_cnt_ff <= '0;
    else if (scan_end || accept)
      scan_cnt_ff <= '0;
    else if (push)
      scan_cnt_ff <= scan_cnt_ff + 1'b1;
  end

  // wrap point where the right edge was crossed
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      pushed_ff <= '0;
      wrap_base_ff <= '0;
    end else if (accept) begin
      pushed_ff <= '0;
      wrap_base_ff <= '0;
    end else begin
      if (push)
        pushed_ff <= pushed_ff + 1'b1;
      if (capturing && frame_end)
        wrap_base_ff <= pushed_ff + (`RAW_AW+1)'(push);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data memory

  logic [`RAW_W-1:0] raw_mem [RAW_DEPTH];
  logic [`CNT_W-1:0] cnt_mem [`SCAN_COUNT];
  logic [`WORD_W-1:0] proc_mem [2 ** `PROC_AW];

  // drain in detection order from array top
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN)
      drained_ff <= '0;
    else if (accept)
      drained_ff <= '0;
    else if (pop)
      drained_ff <= drained_ff + 1'b1;
  end

  always_ff @(posedge CLOCK) begin
    if (pop)
      raw_mem[drained_ff[`RAW_AW-1:0]] <= cache_mem[crd_ff[CACHE_AW-1:0]];
  end

  // count stored at its horizontal position
  always_ff @(posedge CLOCK) begin
    if (finish)
      cnt_mem[start_h_ff] <= cnt_mem[start_h_ff] + cnt_now;
    else if (capturing && scan_end)
      cnt_mem[h_ff] <= cnt_now;
  end

  always_ff @(posedge CLOCK) begin
    if (PROC_WE)
      proc_mem[PROC_ADDR] <= PROC_WDATA;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read-out onto the fast data bus

  rd_cmd_t cmd_ff;
  logic pend_ff;
  logic [`RAW_AW:0] vsum;
  logic [`RAW_AW-1:0] raw_rd_ff;
  logic [`WORD_W-1:0] ptr_acc_ff;

  assign vsum = wrap_base_ff + (`RAW_AW+1)'(RD_CMD.addr);

  // reorder for reads, dump stays raw
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      cmd_ff <= '{mode: RD_DUMP, addr: '0};
      pend_ff <= 1'b0;
      raw_rd_ff <= '0;
    end else begin
      pend_ff <= RD_REQ;
      if (RD_REQ) begin
        cmd_ff <= RD_CMD;
        if (RD_CMD.mode == RD_VERT)
          raw_rd_ff <= (vsum >= pushed_ff) ? `RAW_AW'(vsum - pushed_ff) : vsum[`RAW_AW-1:0];
        else
          raw_rd_ff <= RD_CMD.addr[`RAW_AW-1:0];
      end
    end
  end

  // answer bus, counts as running pointers
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      RD_ANS <= '0;
      ptr_acc_ff <= '0;
    end else begin
      RD_ANS.valid <= pend_ff;
      if (pend_ff) begin
        case (cmd_ff.mode)
          RD_DUMP, RD_VERT: RD_ANS.data <= `WORD_W'(raw_mem[raw_rd_ff]);
          RD_COUNT: RD_ANS.data <= `WORD_W'(cnt_mem[cmd_ff.addr[`H_W-1:0]]);
          RD_PTR: begin
            if (cmd_ff.addr[`H_W-1:0] == '0) begin
              RD_ANS.data <= '0;
              ptr_acc_ff <= `WORD_W'(cnt_mem[0]);
            end else begin
              RD_ANS.data <= ptr_acc_ff;
              ptr_acc_ff <= ptr_acc_ff + `WORD_W'(cnt_mem[cmd_ff.addr[`H_W-1:0]]);
            end
          end
          RD_PROC: RD_ANS.data <= proc_mem[cmd_ff.addr[`PROC_AW-1:0]];
          default: RD_ANS.data <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // writing-side supervision

  logic sweep_d_ff;
  logic [15:0] grat_cnt_ff;
  logic [31:0] win_ff, on_ff;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      sweep_d_ff <= 1'b0;
      grat_cnt_ff <= '0;
      GRAT_SELECT <= 1'b0;
    end else begin
      sweep_d_ff <= SWEEP_GATE;
      if (sweep_d_ff && !SWEEP_GATE)
        grat_cnt_ff <= 16'(`GRAT_CYC);
      else if (grat_cnt_ff != '0)
        grat_cnt_ff <= grat_cnt_ff - 1'b1;
      GRAT_SELECT <= (grat_cnt_ff != '0);
    end
  end

  // duty cycle over a fixed window; judged per window, not instantly
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      win_ff <= '0;
      on_ff <= '0;
      INTENSITY_LIMIT <= 1'b0;
    end else if (win_ff == 32'(DUTY_WIN - 1)) begin
      win_ff <= '0;
      on_ff <= '0;
      INTENSITY_LIMIT <= (on_ff + 32'(WRITE_BEAM_ON)) > DUTY_LIM;
    end else begin
      win_ff <= win_ff + 1'b1;
      on_ff <= on_ff + 32'(WRITE_BEAM_ON);
    end
  end

endmodule // scan_target_data_capture

// file: scan_capture_props.sv
// checker for the scan target capture block ports
`timescale 1ns/1ns
module scan_capture_props import scan_capture_pkg::*; #(
  parameter int PIX_DIV = 4
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // watched ports
  input wire logic TV_MODE,
  input wire logic TV_XGATE_IN,
  input wire logic READ_STEP,
  input wire logic X_RAMP_SYNC,
  input wire logic SWEEP_GATE,
  input wire logic GRAT_SELECT,
  input wire logic DIG_START,
  input wire logic DIG_BUSY,
  input wire logic DIG_DONE,
  input wire logic CACHE_OVERFLOW,
  input wire logic RD_REQ,
  input wire scan_capture_pkg::rd_ans_t RD_ANS
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////////////////////////////////////
  chk_step_period: assert property (READ_STEP |-> ##PIX_DIV READ_STEP)
    else $error("read step period wrong");
  chk_step_single: assert property (READ_STEP |=> !READ_STEP)
    else $error("read step longer than one cycle");
  // done cycle excluded; idle is reached on the same edge that raises done
  chk_start_busy: assert property (DIG_START && !DIG_BUSY && !DIG_DONE && !TV_MODE
    |=> DIG_BUSY && !CACHE_OVERFLOW) else $error("digitize not started");
  chk_tv_refuse: assert property (TV_MODE && !DIG_BUSY |=> !DIG_BUSY)
    else $error("digitize started in tv mode");
  chk_done_single: assert property (DIG_DONE |=> !DIG_DONE)
    else $error("done longer than one cycle");
  chk_done_ends: assert property ($rose(DIG_DONE) |-> !DIG_BUSY && $past(DIG_BUSY))
    else $error("done without busy ending");
  chk_read_answer: assert property (RD_REQ |-> ##2 RD_ANS.valid)
    else $error("read answer late");
  chk_answer_cause: assert property (RD_ANS.valid |-> $past(RD_REQ, 2))
    else $error("answer without request");
  chk_grat_hold: assert property ($fell(SWEEP_GATE) |-> ##2 GRAT_SELECT[*8])
    else $error("graticule not selected after sweep");
  chk_tv_xsync: assert property (TV_MODE && $rose(TV_XGATE_IN) |-> ##[1:2] X_RAMP_SYNC)
    else $error("tv sync pulse missing");
  ////////////////////////////////////////////////////////////////////////
  cover property (DIG_START && !DIG_BUSY ##1 DIG_BUSY);
  cover property (RD_ANS.valid);
  cover property ($fell(SWEEP_GATE));
  cover property (TV_MODE && X_RAMP_SYNC);
endmodule // scan_capture_props

bind scan_target_data_capture scan_capture_props #(.PIX_DIV(PIX_DIV)) i_props (
  .CLOCK(CLOCK), .RSTN(RSTN), .TV_MODE(TV_MODE), .TV_XGATE_IN(TV_XGATE_IN),
  .READ_STEP(READ_STEP), .X_RAMP_SYNC(X_RAMP_SYNC), .SWEEP_GATE(SWEEP_GATE),
  .GRAT_SELECT(GRAT_SELECT), .DIG_START(DIG_START), .DIG_BUSY(DIG_BUSY),
  .DIG_DONE(DIG_DONE), .CACHE_OVERFLOW(CACHE_OVERFLOW), .RD_REQ(RD_REQ), .RD_ANS(RD_ANS));

// file: scan_target_model.sv
// target model: one written band seen by the reading beam
`timescale 1ns/1ns
module scan_target_model #(
  parameter int BAND_LO = 100,
  parameter int BAND_HI = 140
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // beam and video
  input wire logic read_step,
  output logic video
);
  logic [8:0] v_ff;
  // beam row follows each step
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      v_ff <= 9'h000;
    end else if (read_step) begin
      v_ff <= v_ff + 9'h001;
    end
  end
  // a level at all times, never left floating
  assign video = (v_ff >= BAND_LO) && (v_ff < BAND_HI);
endmodule // scan_target_model

// file: scan_target_data_capture_tb.sv
// self-checking bench for the scan target capture block
`timescale 1ns/1ns
module scan_target_data_capture_tb;
  import scan_capture_pkg::*;
  logic clock, rstn, video, tv_mode, tv_x, tv_y, read_step, x_sync, y_sync;
  logic sweep, beam_on, grat_sel, int_lim, dig_start, dig_busy, dig_done, overflow;
  logic rd_req, proc_we;
  rd_cmd_t rd_cmd;
  logic [9:0] proc_addr;
  logic [15:0] proc_wdata, d;
  rd_ans_t rd_ans;
  int err_total, compares, cycles, n, m;
  ////////////////////////////////////////////////////////////////////////
  scan_target_data_capture #(.PIX_DIV(4), .DUTY_WIN(100)) i_dut (
    .CLOCK(clock), .RSTN(rstn), .VIDEO_IN(video), .TV_MODE(tv_mode),
    .TV_XGATE_IN(tv_x), .TV_YGATE_IN(tv_y), .READ_STEP(read_step),
    .X_RAMP_SYNC(x_sync), .Y_RAMP_SYNC(y_sync), .SWEEP_GATE(sweep),
    .WRITE_BEAM_ON(beam_on), .GRAT_SELECT(grat_sel), .INTENSITY_LIMIT(int_lim),
    .DIG_START(dig_start), .DIG_BUSY(dig_busy), .DIG_DONE(dig_done),
    .CACHE_OVERFLOW(overflow), .RD_REQ(rd_req), .RD_CMD(rd_cmd), .PROC_WE(proc_we),
    .PROC_ADDR(proc_addr), .PROC_WDATA(proc_wdata), .RD_ANS(rd_ans));
  scan_target_model i_target (.clock(clock), .rstn(rstn), .read_step(read_step),
    .video(video));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // whole run needs about 6800 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      $display("MISMATCH t=%0t run hung", $time);
      test_done();
    end
  end
  task automatic rd(input rd_mode_t md, input logic [11:0] a);
    rd_cmd = '{mode: md, addr: a};
    rd_req = 1;
    tick(1);
    rd_req = 0;
    n = 0;
    while (rd_ans.valid !== 1'b1 && n < 4) begin tick(1); n++; end
    check(16'(rd_ans.valid), 16'h0001, "answer valid");
    d = rd_ans.data;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_step_scan();
    m = 0;
    repeat (40) begin tick(1); m += int'(read_step); end
    check(16'(m), 16'h000a, "step count");
    n = 0;
    while (y_sync !== 1'b1 && n < 3000) begin tick(1); n++; end
    tick(1);
    n = 1;
    while (y_sync !== 1'b1 && n < 3000) begin tick(1); n++; end
    check(16'(n), 16'h0800, "scan period");
    $display("test step_scan done");
  endtask
  task automatic t_proc();
    logic [9:0] ad[3] = '{10'h000, 10'h001, 10'h3ff};
    logic [15:0] dt[3] = '{16'ha5c3, 16'hffff, 16'h8001};
    for (int i = 0; i < 3; i++) begin
      proc_we = 1; proc_addr = ad[i]; proc_wdata = dt[i];
      tick(1);
    end
    proc_we = 0;
    for (int i = 0; i < 3; i++) begin
      rd(RD_PROC, {2'b00, ad[i]});
      check(d, dt[i], "processed word");
    end
    for (int k = 0; k < 4; k++) rd(rd_mode_t'(k), 12'h000);
    $display("test proc done");
  endtask
  task automatic t_tv();
    tv_mode = 1;
    dig_start = 1; tick(1); dig_start = 0; tick(3);
    check(16'(dig_busy), 16'h0000, "busy in tv mode");
    tv_x = 1; tv_y = 1; n = 0; m = 0;
    repeat (6) begin tick(1); n += int'(x_sync); m += int'(y_sync); end
    check(16'(n), 16'h0001, "x sync pulses");
    check(16'(m), 16'h0001, "y sync pulses");
    tv_x = 0; tv_y = 0; tv_mode = 0; tick(2);
    $display("test tv done");
  endtask
  task automatic t_grat_duty();
    sweep = 1; tick(10); sweep = 0; n = 0;
    repeat (600) begin tick(1); n += int'(grat_sel); end
    check(16'(n), 16'h01f4, "graticule time");
    beam_on = 1; tick(300);
    check(16'(int_lim), 16'h0001, "limit set");
    beam_on = 0; tick(300);
    check(16'(int_lim), 16'h0000, "limit cleared");
    $display("test grat_duty done");
  endtask
  task automatic t_digitize();
    // start on a scan boundary so the first two points are known
    n = 0;
    while (y_sync !== 1'b1 && n < 3000) begin tick(1); n++; end
    dig_start = 1; tick(1); dig_start = 0; tick(1);
    check(16'(dig_busy), 16'h0001, "busy after start");
    dig_start = 1; tick(1); dig_start = 0; tick(600);
    check(16'(dig_busy), 16'h0001, "still busy");
    check(16'(dig_done), 16'h0000, "not done early");
    check(16'(overflow), 16'h0000, "cache holds scan");
    // band of the target model: rises at row 100, falls at row 140
    rd(RD_DUMP, 12'h000);
    check(d, 16'h0264, "rising edge point");
    rd(RD_DUMP, 12'h001);
    check(d, 16'h008c, "falling edge point");
    rd(RD_VERT, 12'h000);
    check(d, 16'h0264, "ordered first point");
    rstn = 0; tick(2); rstn = 1; tick(1);
    check(16'(dig_busy), 16'h0000, "idle after reset");
    $display("test digitize done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, tv_mode, tv_x, tv_y, sweep, beam_on, dig_start, rd_req, proc_we} = '0;
    rd_cmd = '{mode: RD_DUMP, addr: 12'h000};
    proc_addr = '0; proc_wdata = '0;
    err_total = 0; compares = 0;
    tick(16);
    rstn = 1;
    t_step_scan();
    t_proc();
    t_tv();
    t_grat_duty();
    t_digitize();
    test_done();
  end
endmodule // scan_target_data_capture_tb
